// file: logic/i2c_mem_slave.sv
// Two-wire serial slave front end of a byte memory.
//
// Functional notes
// - Master starts transfers and drives the clock.
// - Data falling during clock high is start.
// - Data rising during clock high is stop.
// - Bytes committed at bus speed, no wait.
// - Acknowledge is never withheld to show busy.
// - Receiver pulls data low on ninth clock.
// - Transmitter releases data on ninth clock.
// - Stop before low acknowledge aborts to standby.
// - Release data line after a not-acknowledge.
// - Address word: type, select, direction.
// - First four bits must match type code.
// - Next three bits must match select pins.
// - Eighth bit: zero write, one read.
// - Mismatch: no acknowledge, standby until start.
// - Two address bytes, high first, each acknowledged.
// - Data bytes follow, each with acknowledge.
// - Direction decides who drives the data line.
// - Write bytes are received then acknowledged.
// - Read bytes sent, then master acknowledge sampled.
// - Write protect high blocks all writes.
// - Reads served whatever write protect shows.
// - Floating write protect counts as low; here wp_in has no pull-down and must be driven.
// - Address advances per byte and wraps.
// - Pointer kept after stop for current read.
`timescale 1ns/1ps
module i2c_mem_slave
   import i2c_mem_pkg::*;
#(
   parameter logic [TYPE_W-1:0] DEV_TYPE = DEV_TYPE_DEFAULT
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic wp_in,
   input wire logic [SEL_W-1:0] device_select_pins
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic rst_meta_ff;
   logic link_rst_ff;
   logic scl_meta_ff;
   logic scl_s_ff;
   logic scl_q_ff;
   logic sda_meta_ff;
   logic sda_s_ff;
   logic sda_q_ff;
   logic wp_meta_ff;
   logic wp_s_ff;
   logic [SEL_W-1:0] sel_meta_ff;
   logic [SEL_W-1:0] sel_s_ff;

   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   link_state_t state_ff;
   byte_role_t role_ff;
   logic [2:0] bitcnt_ff;
   logic byte_full_ff;
   logic [DATA_W-1:0] shift_ff;
   logic read_dir_ff;
   logic mack_low_ff;
   logic sda_oe_ff;
   logic [HI_W-1:0] addr_hi_ff;
   logic [ADDR_W-1:0] ptr_ff;
   logic [DATA_W-1:0] rd_data_ff;

   logic byte_end;
   logic dev_match;
   logic ack_end;
   logic tx_end;
   logic mack_end;
   logic [ADDR_W-1:0] ptr_inc;

   logic req_valid;
   mem_req_t req_word;
   logic req_ready;
   logic req_pulse;
   mem_req_t req_got;
   logic mem_wr;
   logic mem_rd;
   logic [DATA_W-1:0] mem_rdata;
   logic rsp_valid_ff;
   mem_rsp_t rsp_word;
   logic rsp_ready;
   logic rsp_pulse;
   mem_rsp_t rsp_got;

   // ---------------------------------------------------------------
   // Link domain reset and input synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge link_clk) begin
      rst_meta_ff <= srst;
      link_rst_ff <= rst_meta_ff;
   end

   // The pins are asynchronous to the oversampling clock.
   always_ff @(posedge link_clk) begin
      scl_meta_ff <= scl_in;
      sda_meta_ff <= sda_in;
      wp_meta_ff <= wp_in;
      sel_meta_ff <= device_select_pins;
   end

   always_ff @(posedge link_clk) begin
      if (link_rst_ff) begin
         scl_s_ff <= 1'b1;
         scl_q_ff <= 1'b1;
         sda_s_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         wp_s_ff <= 1'b0;
         sel_s_ff <= '0;
      end else begin
         scl_s_ff <= scl_meta_ff;
         scl_q_ff <= scl_s_ff;
         sda_s_ff <= sda_meta_ff;
         sda_q_ff <= sda_s_ff;
         wp_s_ff <= wp_meta_ff;
         sel_s_ff <= sel_meta_ff;
      end
   end

   // ---------------------------------------------------------------
   // Bus events
   // ---------------------------------------------------------------
   // Only the master clocks the bus; the clock line is input only.
   assign scl_rise = scl_s_ff & ~scl_q_ff;
   assign scl_fall = ~scl_s_ff & scl_q_ff;
   // Data moving while clock is high is only legal as start or stop.
   assign start_ev = scl_s_ff & scl_q_ff & sda_q_ff & ~sda_s_ff;
   assign stop_ev = scl_s_ff & scl_q_ff & ~sda_q_ff & sda_s_ff;

   // ---------------------------------------------------------------
   // Byte decisions
   // ---------------------------------------------------------------
   assign byte_end = (state_ff == ST_RX) & scl_fall & byte_full_ff;
   assign dev_match = (shift_ff[TYPE_MSB:TYPE_LSB] == DEV_TYPE)
      & (shift_ff[SEL_MSB:SEL_LSB] == sel_s_ff);
   assign ack_end = (state_ff == ST_ACK) & scl_fall;
   assign tx_end = (state_ff == ST_TX) & scl_fall & (bitcnt_ff == BIT_LAST);
   assign mack_end = (state_ff == ST_MACK) & scl_fall;
   // The pointer width makes the last location roll over to zero.
   assign ptr_inc = ptr_ff + PTR_STEP;

   // ---------------------------------------------------------------
   // Link state machine
   // ---------------------------------------------------------------
   always_ff @(posedge link_clk) begin
      if (link_rst_ff) begin
         state_ff <= ST_IDLE;
         role_ff <= ROLE_DEV;
         read_dir_ff <= 1'b0;
      end else if (start_ev) begin
         // A repeated start restarts the address word from any state.
         state_ff <= ST_RX;
         role_ff <= ROLE_DEV;
      end else if (stop_ev) begin
         // Anything not yet acknowledged is simply dropped.
         state_ff <= ST_IDLE;
         role_ff <= ROLE_DEV;
      end else begin
         case (state_ff)
            ST_RX: begin
               if (byte_end) begin
                  if (role_ff == ROLE_DEV && !dev_match) begin
                     state_ff <= ST_IDLE;
                  end else begin
                     // Acknowledge is given at once, never held back.
                     state_ff <= ST_ACK;
                  end
                  if (role_ff == ROLE_DEV) begin
                     read_dir_ff <= (shift_ff[DIR_POS] == DIR_READ);
                  end
               end
            end
            ST_ACK: begin
               if (ack_end) begin
                  if (role_ff == ROLE_DEV && read_dir_ff) begin
                     state_ff <= ST_TX;
                     role_ff <= ROLE_DATA;
                  end else begin
                     state_ff <= ST_RX;
                     case (role_ff)
                        ROLE_DEV: role_ff <= ROLE_AHI;
                        ROLE_AHI: role_ff <= ROLE_ALO;
                        default: role_ff <= ROLE_DATA;
                     endcase
                  end
               end
            end
            ST_TX: begin
               if (tx_end) begin
                  state_ff <= ST_MACK;
               end
            end
            ST_MACK: begin
               if (mack_end) begin
                  // After a not-acknowledge the bus is left free.
                  state_ff <= mack_low_ff ? ST_TX : ST_IDLE;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Bit counter and shift register
   // ---------------------------------------------------------------
   always_ff @(posedge link_clk) begin
      if (link_rst_ff || start_ev || stop_ev) begin
         bitcnt_ff <= BIT_FIRST;
         byte_full_ff <= 1'b0;
         shift_ff <= BYTE_RESET;
      end else if (state_ff == ST_RX) begin
         if (byte_end) begin
            bitcnt_ff <= BIT_FIRST;
            byte_full_ff <= 1'b0;
         end else if (scl_rise) begin
            // Incoming bits are taken most significant first.
            shift_ff <= {shift_ff[DATA_W-2:0], sda_s_ff};
            bitcnt_ff <= bitcnt_ff + 3'h1;
            byte_full_ff <= (bitcnt_ff == BIT_LAST);
         end
      end else if ((ack_end && role_ff == ROLE_DEV && read_dir_ff)
                   || (mack_end && mack_low_ff)) begin
         shift_ff <= rd_data_ff;
         bitcnt_ff <= BIT_FIRST;
      end else if ((state_ff == ST_TX) && scl_fall) begin
         shift_ff <= {shift_ff[DATA_W-2:0], 1'b0};
         bitcnt_ff <= bitcnt_ff + 3'h1;
      end
   end

   // ---------------------------------------------------------------
   // Master acknowledge capture
   // ---------------------------------------------------------------
   always_ff @(posedge link_clk) begin
      if (link_rst_ff) begin
         mack_low_ff <= 1'b0;
      end else if ((state_ff == ST_MACK) && scl_rise) begin
         mack_low_ff <= ~sda_s_ff;
      end
   end

   // ---------------------------------------------------------------
   // Open-drain data driver
   // ---------------------------------------------------------------
   // Only a low is ever driven; the pull-up supplies the high level.
   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_ff;

   always_ff @(posedge link_clk) begin
      if (link_rst_ff || start_ev || stop_ev) begin
         sda_oe_ff <= 1'b0;
      end else if (byte_end) begin
         sda_oe_ff <= (role_ff != ROLE_DEV) || dev_match;
      end else if (ack_end) begin
         sda_oe_ff <= (role_ff == ROLE_DEV) && read_dir_ff && !rd_data_ff[DATA_W-1];
      end else if (tx_end) begin
         sda_oe_ff <= 1'b0;
      end else if (mack_end) begin
         sda_oe_ff <= mack_low_ff && !rd_data_ff[DATA_W-1];
      end else if ((state_ff == ST_TX) && scl_fall) begin
         sda_oe_ff <= !shift_ff[DATA_W-2];
      end
   end

   // ---------------------------------------------------------------
   // Address pointer
   // ---------------------------------------------------------------
   // The pointer survives a stop, so a read without address goes on.
   always_ff @(posedge link_clk) begin
      if (link_rst_ff) begin
         addr_hi_ff <= '0;
         ptr_ff <= PTR_RESET;
      end else if (byte_end && role_ff == ROLE_AHI) begin
         // The top bits of the high byte are ignored.
         addr_hi_ff <= shift_ff[HI_W-1:0];
      end else if (byte_end && role_ff == ROLE_ALO) begin
         ptr_ff <= {addr_hi_ff, shift_ff};
      end else if ((ack_end && role_ff == ROLE_DATA) || tx_end) begin
         ptr_ff <= ptr_inc;
      end
   end

   // ---------------------------------------------------------------
   // Memory requests
   // ---------------------------------------------------------------
   // A write leaves as soon as its acknowledge ends; no wait follows.
   // A read is prefetched so the byte is ready at the next falling edge.
   always_comb begin
      req_valid = 1'b0;
      req_word = '0;
      if (ack_end && role_ff == ROLE_DATA && !wp_s_ff) begin
         req_valid = 1'b1;
         req_word.we = 1'b1;
         req_word.addr = ptr_ff;
         req_word.data = shift_ff;
      end else if (byte_end && role_ff == ROLE_DEV && dev_match
                   && shift_ff[DIR_POS] == DIR_READ) begin
         req_valid = 1'b1;
         req_word.addr = ptr_ff;
      end else if (tx_end) begin
         req_valid = 1'b1;
         req_word.addr = ptr_inc;
      end
   end

   always_ff @(posedge link_clk) begin
      if (link_rst_ff) begin
         rd_data_ff <= BYTE_RESET;
      end else if (rsp_pulse) begin
         rd_data_ff <= rsp_got.rdata;
      end
   end

   // ---------------------------------------------------------------
   // Crossings and memory
   // ---------------------------------------------------------------
   // A request met while the previous one is in flight is lost; the
   // round trip is far shorter than one bus bit at the rated rates.
   cdc_handshake #(
      .W($bits(mem_req_t))
   ) u_req_cdc (
      .src_clk(link_clk),
      .src_rst(link_rst_ff),
      .src_valid(req_valid),
      .src_data(req_word),
      .src_ready(req_ready),
      .dst_clk(clock),
      .dst_rst(srst),
      .dst_valid(req_pulse),
      .dst_data(req_got)
   );

   assign mem_wr = req_pulse & req_got.we;
   assign mem_rd = req_pulse & ~req_got.we;

   mem_array #(
      .AW(ADDR_W),
      .DW(DATA_W)
   ) u_mem (
      .clock(clock),
      .wr_en(mem_wr),
      .rd_en(mem_rd),
      .addr(req_got.addr),
      .wdata(req_got.data),
      .rdata_ff(mem_rdata)
   );

   always_ff @(posedge clock) begin
      if (srst) begin
         rsp_valid_ff <= 1'b0;
      end else begin
         rsp_valid_ff <= mem_rd;
      end
   end

   assign rsp_word.rdata = mem_rdata;

   cdc_handshake #(
      .W($bits(mem_rsp_t))
   ) u_rsp_cdc (
      .src_clk(clock),
      .src_rst(srst),
      .src_valid(rsp_valid_ff),
      .src_data(rsp_word),
      .src_ready(rsp_ready),
      .dst_clk(link_clk),
      .dst_rst(link_rst_ff),
      .dst_valid(rsp_pulse),
      .dst_data(rsp_got)
   );

endmodule : i2c_mem_slave

// file: shared/i2c_mem_pkg.sv
// Shared constants, types and carriers of the two-wire memory slave.
package i2c_mem_pkg;

   // -----------------------------------------------------------------
   // Geometry
   // -----------------------------------------------------------------
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int SEL_W = 3;
   localparam int TYPE_W = 4;
   localparam int HI_W = ADDR_W - DATA_W;

   // -----------------------------------------------------------------
   // Device address word layout
   // -----------------------------------------------------------------
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 4;
   localparam int SEL_MSB = 3;
   localparam int SEL_LSB = 1;
   localparam int DIR_POS = 0;
   localparam logic DIR_READ = 1'b1;
   // Arbitrary value; the real type code is set through the top parameter.
   localparam logic [TYPE_W-1:0] DEV_TYPE_DEFAULT = 4'h6;

   // -----------------------------------------------------------------
   // Counts and reset values
   // -----------------------------------------------------------------
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [ADDR_W-1:0] PTR_RESET = 13'h0000;
   localparam logic [ADDR_W-1:0] PTR_STEP = 13'h0001;
   localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;

   // -----------------------------------------------------------------
   // States and carriers
   // -----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RX = 5'b00010,
      ST_ACK = 5'b00100,
      ST_TX = 5'b01000,
      ST_MACK = 5'b10000
   } link_state_t;

   typedef enum logic [3:0] {
      ROLE_DEV = 4'b0001,
      ROLE_AHI = 4'b0010,
      ROLE_ALO = 4'b0100,
      ROLE_DATA = 4'b1000
   } byte_role_t;

   typedef struct packed {
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } mem_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
   } mem_rsp_t;

endpackage : i2c_mem_pkg

// file: logic/mem_array.sv
// Byte memory array with registered read data.
`timescale 1ns/1ps
module mem_array #(
   parameter int AW = 13,
   parameter int DW = 8
) (
   input wire logic clock,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata_ff
);

   logic [DW-1:0] cells [0:(1<<AW)-1];

   // Contents are not reset, as in the nonvolatile array they model.
   always_ff @(posedge clock) begin
      if (wr_en) begin
         cells[addr] <= wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (rd_en) begin
         rdata_ff <= cells[addr];
      end
   end

endmodule : mem_array

// file: logic/cdc_handshake.sv
// Toggle handshake that carries one word between two clock domains.
`timescale 1ns/1ps
module cdc_handshake #(
   parameter int W = 8
) (
   input wire logic src_clk,
   input wire logic src_rst,
   input wire logic src_valid,
   input wire logic [W-1:0] src_data,
   output logic src_ready,
   input wire logic dst_clk,
   input wire logic dst_rst,
   output logic dst_valid,
   output logic [W-1:0] dst_data
);

   logic req_tog_ff;
   logic [W-1:0] hold_ff;
   logic ack_meta_ff;
   logic ack_s_ff;
   logic req_meta_ff;
   logic req_s_ff;
   logic req_q_ff;

   // The word is held stable until the far side has toggled back.
   assign src_ready = (req_tog_ff == ack_s_ff);

   always_ff @(posedge src_clk) begin
      if (src_rst) begin
         req_tog_ff <= 1'b0;
         hold_ff <= '0;
      end else if (src_valid && src_ready) begin
         req_tog_ff <= ~req_tog_ff;
         hold_ff <= src_data;
      end
   end

   always_ff @(posedge src_clk) begin
      ack_meta_ff <= req_q_ff;
      ack_s_ff <= ack_meta_ff;
   end

   always_ff @(posedge dst_clk) begin
      if (dst_rst) begin
         req_meta_ff <= 1'b0;
         req_s_ff <= 1'b0;
         req_q_ff <= 1'b0;
      end else begin
         req_meta_ff <= req_tog_ff;
         req_s_ff <= req_meta_ff;
         req_q_ff <= req_s_ff;
      end
   end

   always_ff @(posedge dst_clk) begin
      dst_valid <= ~dst_rst & (req_s_ff ^ req_q_ff);
      if (dst_rst) begin
         dst_data <= '0;
      end else if (req_s_ff ^ req_q_ff) begin
         dst_data <= hold_ff;
      end
   end

endmodule : cdc_handshake

// file: dv/i2c_master_model.sv
// Behavioural two-wire bus master that drives the serial clock and data line.
`timescale 1ns/1ps
module i2c_master_model #(
   parameter int Q = 13
) (
   input wire logic clock,
   input wire logic sda_line,
   output logic scl_out,
   output logic sda_drv
);
   // ------------------------------------------------------------
   // Bus phases
   // ------------------------------------------------------------
   // Only this model moves the clock; it rests high between frames.
   initial begin
      scl_out = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic wait_q;
      repeat (Q) @(posedge clock);
   endtask : wait_q

   task automatic start;
      @(posedge clock) sda_drv <= 1'b1;
      wait_q();
      scl_out <= 1'b1;
      wait_q();
      sda_drv <= 1'b0;
      wait_q();
      scl_out <= 1'b0;
      wait_q();
   endtask : start

   task automatic stop;
      @(posedge clock) sda_drv <= 1'b0;
      wait_q();
      scl_out <= 1'b1;
      wait_q();
      sda_drv <= 1'b1;
      wait_q();
   endtask : stop

   // Data moves only while the clock is low; the level is sampled mid-high.
   task automatic bit_xfer(input logic b, output logic s);
      @(posedge clock) sda_drv <= b;
      wait_q();
      scl_out <= 1'b1;
      wait_q();
      s = sda_line;
      wait_q();
      scl_out <= 1'b0;
      wait_q();
   endtask : bit_xfer

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], s);
      end
      bit_xfer(1'b1, s);
      ack = ~s;
   endtask : wr_byte

   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic s;
      d = 8'h00;
      for (int i = 0; i < 8; i++) begin
         bit_xfer(1'b1, s);
         d = {d[6:0], s};
      end
      bit_xfer(last, s);
   endtask : rd_byte
endmodule : i2c_master_model

// file: dv/i2c_mem_slave_props.sv
// Concurrent checks on the serial side of the two-wire memory slave.
`timescale 1ns/1ps
module i2c_mem_slave_props
   import i2c_mem_pkg::*;
#(
   parameter logic [TYPE_W-1:0] DEV_TYPE = DEV_TYPE_DEFAULT
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic wp_in,
   input wire logic [SEL_W-1:0] device_select_pins
);
   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic scl_q_ff, sda_q_ff, busy_ff, first_ff, sel_ff, rd_ff;
   logic [3:0] cnt_ff, rst_l_ff;
   logic [7:0] sr_ff;
   logic rise_ev, fall_ev, start_ev, stop_ev, match;
   assign rise_ev = scl_in & ~scl_q_ff;
   assign fall_ev = ~scl_in & scl_q_ff;
   assign start_ev = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
   assign stop_ev = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
   assign match = (sr_ff[7:4] == DEV_TYPE) && (sr_ff[3:1] == device_select_pins);

   always_ff @(posedge link_clk) begin
      scl_q_ff <= srst | scl_in;
      rst_l_ff <= {rst_l_ff[2:0], srst};
      sda_q_ff <= srst | sda_in;
   end

   // The count of clock rises within a byte; 8 marks the acknowledge slot.
   always_ff @(posedge link_clk) begin
      if (srst) begin
         {busy_ff, first_ff, sel_ff, rd_ff} <= 4'h0;
         cnt_ff <= 4'h0;
         sr_ff <= 8'h00;
      end else if (start_ev) begin
         busy_ff <= 1'b1;
         first_ff <= 1'b1;
         cnt_ff <= 4'h0;
      end else if (stop_ev) begin
         busy_ff <= 1'b0;
      end else if (rise_ev) begin
         sr_ff <= {sr_ff[6:0], sda_in};
         cnt_ff <= (cnt_ff == 4'h8) ? 4'h0 : cnt_ff + 4'h1;
         if (cnt_ff == 4'h8 && first_ff) begin
            first_ff <= 1'b0;
            sel_ff <= match;
            rd_ff <= sr_ff[0];
         end
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (srst | (|rst_l_ff));

   property p_sda_out_low;
      sda_out == 1'b0;
   endproperty
   a_sda_out_low: assert property (p_sda_out_low) else $error("data driven high");

   property p_oe_on_scl_low;
      $changed(sda_oe) |-> !scl_in;
   endproperty
   a_oe_on_scl_low: assert property (p_oe_on_scl_low) else $error("data moved with clock high");

   property p_idle_quiet;
      (!busy_ff || (!first_ff && !sel_ff)) |-> !sda_oe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("line driven in standby");

   property p_dev_ack;
      first_ff && match && fall_ev && cnt_ff == 4'h8 |-> ##6 sda_oe;
   endproperty
   a_dev_ack: assert property (p_dev_ack) else $error("address word not acknowledged");

   property p_no_ack_mismatch;
      first_ff && !match && cnt_ff == 4'h8 |-> !sda_oe;
   endproperty
   a_no_ack_mismatch: assert property (p_no_ack_mismatch) else $error("foreign address acknowledged");

   property p_master_bits;
      busy_ff && (first_ff || !rd_ff) && cnt_ff >= 4'h1 && cnt_ff <= 4'h7 |-> !sda_oe;
   endproperty
   a_master_bits: assert property (p_master_bits) else $error("line driven during master bits");

   property p_data_ack;
      busy_ff && !first_ff && sel_ff && !rd_ff && fall_ev && cnt_ff == 4'h8 |-> ##6 sda_oe;
   endproperty
   a_data_ack: assert property (p_data_ack) else $error("written byte not acknowledged");

   property p_ack_stands;
      rise_ev && cnt_ff == 4'h8 && sda_oe |-> sda_oe [*4];
   endproperty
   a_ack_stands: assert property (p_ack_stands) else $error("acknowledge dropped early");

   property p_read_release;
      busy_ff && !first_ff && sel_ff && rd_ff && fall_ev && cnt_ff == 4'h8 |-> ##6 !sda_oe;
   endproperty
   a_read_release: assert property (p_read_release) else $error("line held in master slot");
endmodule : i2c_mem_slave_props

bind i2c_mem_slave i2c_mem_slave_props #(.DEV_TYPE(DEV_TYPE)) props_u (.clock(clock), .srst(srst),
   .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .wp_in(wp_in), .device_select_pins(device_select_pins));

// file: dv/tb_top.sv
// Self-checking testbench of the two-wire memory slave.
`timescale 1ns/1ps
module tb_top;
   import i2c_mem_pkg::*;
   // Arbitrary type code for this bench.
   localparam logic [TYPE_W-1:0] TB_TYPE = 4'h9;
   logic clock, link_clk, srst, wp_in, scl_line, sda_drv, sda_out, sda_oe, sda_line;
   logic [SEL_W-1:0] sel_pins;
   logic [7:0] shadow [logic [ADDR_W-1:0]];
   int err_total, checks_done;
   // The wire is pulled up and falls when either party pulls it.
   assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

   i2c_mem_slave #(.DEV_TYPE(TB_TYPE)) dut_u (.clock(clock), .srst(srst), .link_clk(link_clk),
      .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in),
      .device_select_pins(sel_pins));
   i2c_master_model mst_u (.clock(clock), .sda_line(sda_line), .scl_out(scl_line), .sda_drv(sda_drv));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop;
      if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic put(input logic [7:0] d, input logic exp_ack, input string what);
      logic ack;
      mst_u.wr_byte(d, ack);
      check(what, {15'h0, ack}, {15'h0, exp_ack});
   endtask : put

   task automatic set_addr(input logic [ADDR_W-1:0] a);
      mst_u.start();
      put({TB_TYPE, sel_pins, 1'b0}, 1'b1, "dev ack");
      put({3'h0, a[ADDR_W-1:DATA_W]}, 1'b1, "hi ack");
      put(a[DATA_W-1:0], 1'b1, "lo ack");
   endtask : set_addr

   // Write protect still acknowledges; only the stored copy is left alone.
   task automatic write_at(input logic [ADDR_W-1:0] a, input logic [7:0] base, input int n);
      logic [ADDR_W-1:0] p;
      p = a;
      set_addr(a);
      for (int i = 0; i < n; i++) begin
         put(base + 8'(i), 1'b1, "data ack");
         if (!wp_in) shadow[p] = base + 8'(i);
         p = p + PTR_STEP;
      end
      mst_u.stop();
   endtask : write_at

   task automatic read_from(input logic [ADDR_W-1:0] a, input int n, input logic cur);
      logic [7:0] d;
      logic [ADDR_W-1:0] p;
      p = a;
      if (!cur) set_addr(a);
      mst_u.start();
      put({TB_TYPE, sel_pins, 1'b1}, 1'b1, "read dev ack");
      for (int i = 0; i < n; i++) begin
         mst_u.rd_byte(i == n - 1, d);
         check("read data", {8'h0, d}, {8'h0, shadow[p]});
         p = p + PTR_STEP;
      end
      mst_u.stop();
   endtask : read_from

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset_idle;
      check("sda_oe idle", {15'h0, sda_oe}, 16'h0);
      check("sda_out", {15'h0, sda_out}, 16'h0);
   endtask : t_reset_idle

   task automatic t_page_wrap;
      write_at(13'h1ffe, 8'ha0, 4);
      read_from(13'h1ffe, 3, 1'b0);
      read_from(13'h0001, 1, 1'b1);
   endtask : t_page_wrap

   task automatic t_protect;
      @(posedge clock) wp_in <= 1'b1;
      write_at(13'h0000, 8'h55, 1);
      read_from(13'h0000, 1, 1'b0);
      @(posedge clock) wp_in <= 1'b0;
      write_at(13'h0000, 8'h66, 1);
      read_from(13'h0000, 1, 1'b0);
   endtask : t_protect

   task automatic t_mismatch;
      logic [7:0] w;
      for (int i = 0; i < 5; i++) begin
         if (i == 0) w = 8'h08;
         else if (i == 4) w = {TB_TYPE ^ 4'h1, sel_pins, 1'b1};
         else w = {TB_TYPE, sel_pins ^ (3'h1 << (i - 1)), 1'b0};
         mst_u.start();
         put(w, 1'b0, "foreign word");
         put(8'h00, 1'b0, "after foreign");
         mst_u.stop();
      end
   endtask : t_mismatch

   task automatic t_abort;
      logic s;
      @(posedge clock) sel_pins <= 3'h2;
      @(posedge clock);
      set_addr(13'h0001);
      for (int i = 0; i < 4; i++) begin
         mst_u.bit_xfer(1'b0, s);
      end
      mst_u.stop();
      read_from(13'h0001, 1, 1'b0);
   endtask : t_abort

   // ------------------------------------------------------------
   // Clocks, reset and sequence
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   initial begin
      link_clk = 1'b0;
      #7;
      forever #16 link_clk = ~link_clk;
   end

   initial begin
      srst = 1'b1;
      wp_in = 1'b0;
      sel_pins = 3'h5;
      err_total = 0;
      checks_done = 0;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      repeat (10) @(posedge clock);
      t_reset_idle();
      t_page_wrap();
      t_protect();
      t_mismatch();
      t_abort();
      report_and_stop();
   end

   initial begin
      repeat (100000) @(posedge clock);
      err_total++;
      report_and_stop();
   end
endmodule : tb_top
